//--- rtl/gcf_pkg.sv
// Package: register map, field positions and timing counts of the bus control block
package gcf_pkg;

    // ----------------------------------------
    // Register offsets (byte addresses)
    // ----------------------------------------
    localparam logic [7:0] BUS_CONTROL_OFS = 8'h00; // Control register
    localparam logic [7:0] BUS_STATUS_OFS = 8'h04; // Status code word
    localparam logic [7:0] IRQ_STATUS_OFS = 8'h08; // Sticky events
    localparam logic [7:0] IRQ_MASK_OFS = 8'h0c; // Event mask

    // ----------------------------------------
    // Control field positions
    // ----------------------------------------
    localparam int GENCALL_BIT = 6;  // slave_gencall_handling
    localparam int TXFLUSH_BIT = 7;  // tx_path_flush
    localparam int RXFLUSH_BIT = 8;  // rx_path_flush
    localparam int DMATX_BIT = 9;    // DMA transmit enable
    localparam int DMARX_BIT = 10;   // DMA receive enable

    // ----------------------------------------
    // Reset values and codes
    // ----------------------------------------
    localparam logic [31:0] CONTROL_RST = 32'h0000_0000; // Control reset value
    localparam logic [31:0] STATUS_RST = 32'h0000_0000;  // Status reset value
    localparam logic [7:0] GENCALL_CODE = 8'h00;         // Address byte of a general call
    localparam logic [15:0] GC_STATUS_WORD = 16'h0047;   // Status code (arbitrary value)

    // Interrupt event positions
    localparam int EV_TXFL_DONE = 0; // Transmit flush done
    localparam int EV_RXFL_DONE = 1; // Receive flush done
    localparam int EV_GC_DIRECT = 2; // General call handled directly
    localparam int EV_DMATX_END = 3; // DMA transmit ended
    localparam int EV_NUM = 4;       // Event count

    // ----------------------------------------
    // Timing
    // ----------------------------------------
    localparam int CLK_MHZ = 50;          // System clock rate
    localparam int LINK_PERIOD_NS = 160;  // Bench link clock period
    localparam int LINK_CYC = (LINK_PERIOD_NS * CLK_MHZ + 999) / 1000; // Cycles per link period

    // Link side flush handshake states
    typedef enum logic [1:0] {
        LK_IDLE = 2'b00,
        LK_BUSY = 2'b01,
        LK_DONE = 2'b11
    } link_state_type;

    // Register port bundle
    typedef struct packed {
        logic [7:0] addr;
        logic [31:0] wdata;
        logic wr;
        logic rd;
    } reg_req_type;

endpackage

//--- rtl/gcf_sync3.sv
// Three stage synchroniser with agreement filter
`timescale 1ns/1ps
`default_nettype none
module gcf_sync3 (
    input wire logic clk_in,
    input wire logic rstn_in,
    input wire logic d_in,
    output logic q_out
);
    // Stage state
    typedef struct packed {
        logic s1;
        logic s2;
        logic s3;
        logic q;
    } sync_state_type;

    sync_state_type st_ff; // Registered state
    sync_state_type nxt_st; // Next state

    // ----------------------------------------
    // Next state
    // ----------------------------------------
    always_comb begin
        nxt_st = st_ff;
        nxt_st.s1 = d_in;
        nxt_st.s2 = st_ff.s1;
        nxt_st.s3 = st_ff.s2;
        if (st_ff.s2 == st_ff.s3) begin
            nxt_st.q = st_ff.s3; // Change counts once stages agree
        end
    end

    // Register
    always_ff @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            st_ff <= '0;
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign q_out = st_ff.q;
endmodule
`default_nettype wire

//--- rtl/gcf_flush_link.sv
// Flush handshake: request into link clock domain, done back to system
`timescale 1ns/1ps
`default_nettype none
module gcf_flush_link
    import gcf_pkg::*;
(
    input wire logic clk_in,
    input wire logic rstn_in,
    input wire logic start_in,      // One cycle flush start
    input wire logic link_rise_in,  // Link clock rising edge seen
    output logic path_reset_out,    // Reset of FIFO and fsm, link side
    output logic done_out           // One cycle completion
);
    // Handshake state
    typedef struct packed {
        link_state_type lk;
        logic req;
        logic ack;
        logic done;
    } fl_state_type;

    fl_state_type st_ff; // Registered state
    fl_state_type nxt_st; // Next state

    // ----------------------------------------
    // Request/ack over link clock edges
    // ----------------------------------------
    always_comb begin
        nxt_st = st_ff;
        nxt_st.done = 1'b0;
        if (start_in) begin
            nxt_st.req = 1'b1;
        end
        case (st_ff.lk)
            LK_IDLE: begin
                if (st_ff.req && link_rise_in) begin
                    nxt_st.lk = LK_BUSY; // Request seen on a link edge
                end
            end
            LK_BUSY: begin
                if (link_rise_in) begin
                    nxt_st.lk = LK_DONE; // Path held in reset for a link cycle
                end
            end
            LK_DONE: begin
                nxt_st.req = 1'b0;
                nxt_st.done = 1'b1;
                nxt_st.lk = LK_IDLE;
            end
            default: begin
                nxt_st.lk = LK_IDLE;
            end
        endcase
    end

    // Register
    always_ff @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            st_ff <= '0;
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign path_reset_out = (st_ff.lk == LK_BUSY);
    assign done_out = st_ff.done;
endmodule
`default_nettype wire

//--- rtl/gcf_ctrl.sv
// Bus controller control register: general call, path flushes, DMA transmit idle
`timescale 1ns/1ps
`default_nettype none
module gcf_ctrl
    import gcf_pkg::*;
(
    input wire logic clk_in,
    input wire logic rstn_in,
    input wire logic [7:0] addr_in,
    input wire logic [31:0] wdata_in,
    input wire logic wr_in,
    input wire logic rd_in,
    output logic [31:0] rdata_out,
    input wire logic link_clk_in,        // Bus clock, sampled
    input wire logic gc_valid_in,        // Received address byte strobe
    input wire logic [7:0] gc_byte_in,   // Received address byte
    input wire logic gc_hw_in,           // General call raised by hardware
    output logic rx_fifo_push_out,       // Push general call byte into receive FIFO
    output logic [7:0] rx_fifo_data_out, // Byte pushed
    output logic gc_action_out,          // Direct general call action pulse
    input wire logic tx_fifo_level_in,   // Transmit FIFO holds data
    input wire logic dma_eot_in,         // DMA end of transfer
    output logic dma_tx_req_out,         // DMA transmit request
    output logic tx_path_reset_out,      // Transmit FIFO and fsm reset
    output logic rx_path_reset_out,      // Receive FIFO and fsm reset
    output logic irq_out                 // Level interrupt
);
    // ----------------------------------------
    // State
    // ----------------------------------------
    typedef struct packed {
        logic [31:0] control;    // bus_control
        logic [15:0] status;     // bus_status_reg code word
        logic [EV_NUM-1:0] irq_st;
        logic [EV_NUM-1:0] irq_mask;
        logic [31:0] rdata;
        logic push;
        logic [7:0] push_data;
        logic action;
        logic link_q;            // Previous filtered link clock
    } ctrl_state_type;

    ctrl_state_type st_ff; // Registered state
    ctrl_state_type nxt_st; // Next state

    logic link_sync; // Filtered link clock
    logic link_rise; // Rising edge of link clock
    logic tx_done; // Transmit flush finished
    logic rx_done; // Receive flush finished
    logic tx_start; // Transmit flush starts
    logic rx_start; // Receive flush starts
    logic is_gc; // General call byte seen

    // ----------------------------------------
    // Link clock sampling
    // ----------------------------------------
    gcf_sync3 u_link_sync (
        .clk_in(clk_in),
        .rstn_in(rstn_in),
        .d_in(link_clk_in),
        .q_out(link_sync)
    );
    assign link_rise = link_sync && !st_ff.link_q;

    // Flush starts only on a written 1 while idle
    assign tx_start = wr_in && (addr_in == BUS_CONTROL_OFS) && wdata_in[TXFLUSH_BIT]
        && !st_ff.control[TXFLUSH_BIT];
    assign rx_start = wr_in && (addr_in == BUS_CONTROL_OFS) && wdata_in[RXFLUSH_BIT]
        && !st_ff.control[RXFLUSH_BIT];

    // ----------------------------------------
    // Flush handshakes, one per path
    // ----------------------------------------
    gcf_flush_link u_tx_flush (
        .clk_in(clk_in),
        .rstn_in(rstn_in),
        .start_in(tx_start),
        .link_rise_in(link_rise),
        .path_reset_out(tx_path_reset_out),
        .done_out(tx_done)
    );
    gcf_flush_link u_rx_flush (
        .clk_in(clk_in),
        .rstn_in(rstn_in),
        .start_in(rx_start),
        .link_rise_in(link_rise),
        .path_reset_out(rx_path_reset_out),
        .done_out(rx_done)
    );

    assign is_gc = gc_valid_in && (gc_byte_in == GENCALL_CODE);

    // ----------------------------------------
    // Next state
    // ----------------------------------------
    always_comb begin
        nxt_st = st_ff;
        nxt_st.link_q = link_sync;
        nxt_st.push = 1'b0;
        nxt_st.action = 1'b0;
        nxt_st.rdata = '0;
        // Register writes; flush bits kept out of plain store
        if (wr_in) begin
            case (addr_in)
                BUS_CONTROL_OFS: begin
                    nxt_st.control = wdata_in;
                    nxt_st.control[TXFLUSH_BIT] = st_ff.control[TXFLUSH_BIT] | wdata_in[TXFLUSH_BIT];
                    nxt_st.control[RXFLUSH_BIT] = st_ff.control[RXFLUSH_BIT] | wdata_in[RXFLUSH_BIT];
                end
                IRQ_MASK_OFS: begin
                    nxt_st.irq_mask = wdata_in[EV_NUM-1:0];
                end
                default: begin
                    nxt_st.control = st_ff.control;
                end
            endcase
        end
        // Reads; interrupt status clears on read
        if (rd_in) begin
            case (addr_in)
                BUS_CONTROL_OFS: nxt_st.rdata = st_ff.control;
                BUS_STATUS_OFS: nxt_st.rdata = {16'h0000, st_ff.status};
                IRQ_STATUS_OFS: begin
                    nxt_st.rdata = {{(32-EV_NUM){1'b0}}, st_ff.irq_st};
                    nxt_st.irq_st = '0;
                end
                IRQ_MASK_OFS: nxt_st.rdata = {{(32-EV_NUM){1'b0}}, st_ff.irq_mask};
                default: nxt_st.rdata = '0;
            endcase
        end
        // Flush completion clears the bit
        if (tx_done) begin
            nxt_st.control[TXFLUSH_BIT] = 1'b0;
            nxt_st.irq_st[EV_TXFL_DONE] = 1'b1;
        end
        if (rx_done) begin
            nxt_st.control[RXFLUSH_BIT] = 1'b0;
            nxt_st.irq_st[EV_RXFL_DONE] = 1'b1;
        end
        // General call handling
        if (is_gc) begin
            if (gc_hw_in || !st_ff.control[GENCALL_BIT]) begin
                nxt_st.push = 1'b1;
                nxt_st.push_data = gc_byte_in;
            end else begin
                nxt_st.action = 1'b1;
                nxt_st.status = GC_STATUS_WORD;
                nxt_st.irq_st[EV_GC_DIRECT] = 1'b1;
            end
        end
        // DMA end of transfer turns transmit interface off
        if (dma_eot_in && st_ff.control[DMATX_BIT]) begin
            nxt_st.control[DMATX_BIT] = 1'b0;
            nxt_st.irq_st[EV_DMATX_END] = 1'b1;
        end
    end

    // Register
    always_ff @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            st_ff <= '0;
            st_ff.control <= CONTROL_RST;
            st_ff.status <= STATUS_RST[15:0];
        end else begin
            st_ff <= nxt_st;
        end
    end

    // ----------------------------------------
    // Outputs
    // ----------------------------------------
    assign rdata_out = st_ff.rdata;
    assign rx_fifo_push_out = st_ff.push;
    assign rx_fifo_data_out = st_ff.push_data;
    assign gc_action_out = st_ff.action;
    // No requests while disabled or while the transmit path flushes
    assign dma_tx_req_out = st_ff.control[DMATX_BIT] && tx_fifo_level_in
        && !st_ff.control[TXFLUSH_BIT];
    assign irq_out = |(st_ff.irq_st & st_ff.irq_mask);

    // ----------------------------------------
    // Assertions
    // ----------------------------------------
    property p_dma_idle;
        @(posedge clk_in) disable iff (!rstn_in)
        !st_ff.control[DMATX_BIT] |-> !dma_tx_req_out;
    endproperty
    a_dma_idle: assert property (p_dma_idle) else $error("DMA request while disabled");

    property p_dma_eot;
        @(posedge clk_in) disable iff (!rstn_in)
        (dma_eot_in && st_ff.control[DMATX_BIT]) |=> !st_ff.control[DMATX_BIT];
    endproperty
    a_dma_eot: assert property (p_dma_eot) else $error("DMA enable not cleared at end");

    property p_tx_hold;
        @(posedge clk_in) disable iff (!rstn_in)
        tx_start |=> st_ff.control[TXFLUSH_BIT] [*3];
    endproperty
    a_tx_hold: assert property (p_tx_hold) else $error("Transmit flush bit dropped early");

    property p_tx_clear;
        @(posedge clk_in) disable iff (!rstn_in)
        tx_done |=> !st_ff.control[TXFLUSH_BIT];
    endproperty
    a_tx_clear: assert property (p_tx_clear) else $error("Transmit flush bit not cleared");

    property p_rx_hold;
        @(posedge clk_in) disable iff (!rstn_in)
        $fell(st_ff.control[RXFLUSH_BIT]) |-> $past(rx_done);
    endproperty
    a_rx_hold: assert property (p_rx_hold) else $error("Receive flush bit cleared without done");

    property p_rx_reset;
        @(posedge clk_in) disable iff (!rstn_in)
        rx_start |-> ##[1:40] rx_path_reset_out;
    endproperty
    a_rx_reset: assert property (p_rx_reset) else $error("Receive path never reset");

    property p_gc_transparent;
        @(posedge clk_in) disable iff (!rstn_in)
        (is_gc && (gc_hw_in || !st_ff.control[GENCALL_BIT])) |=> rx_fifo_push_out && !gc_action_out;
    endproperty
    a_gc_transparent: assert property (p_gc_transparent) else $error("General call not pushed");

    property p_gc_direct;
        @(posedge clk_in) disable iff (!rstn_in)
        (is_gc && !gc_hw_in && st_ff.control[GENCALL_BIT])
            |=> gc_action_out && !rx_fifo_push_out && st_ff.status == GC_STATUS_WORD;
    endproperty
    a_gc_direct: assert property (p_gc_direct) else $error("Direct general call wrong");

    property p_cfg_kept;
        @(posedge clk_in) disable iff (!rstn_in)
        (tx_done && !wr_in) |=> st_ff.control[GENCALL_BIT] == $past(st_ff.control[GENCALL_BIT]);
    endproperty
    a_cfg_kept: assert property (p_cfg_kept) else $error("Flush changed configuration");

    // ----------------------------------------
    // Path resets, receive flush bit clear, written zeros, hardware general call
    // ----------------------------------------
    property p_tx_reset;
        @(posedge clk_in) disable iff (!rstn_in)
        tx_start |-> ##[1:40] tx_path_reset_out;
    endproperty
    a_tx_reset: assert property (p_tx_reset) else $error("Transmit path never reset");

    property p_tx_path_bit;
        @(posedge clk_in) disable iff (!rstn_in)
        tx_path_reset_out |-> st_ff.control[TXFLUSH_BIT];
    endproperty
    a_tx_path_bit: assert property (p_tx_path_bit) else $error("Transmit path reset without flush bit");

    property p_rx_path_bit;
        @(posedge clk_in) disable iff (!rstn_in)
        rx_path_reset_out |-> st_ff.control[RXFLUSH_BIT];
    endproperty
    a_rx_path_bit: assert property (p_rx_path_bit) else $error("Receive path reset without flush bit");

    property p_rx_clear;
        @(posedge clk_in) disable iff (!rstn_in)
        rx_done |=> !st_ff.control[RXFLUSH_BIT];
    endproperty
    a_rx_clear: assert property (p_rx_clear) else $error("Receive flush bit not cleared");

    property p_tx_zero_write;
        @(posedge clk_in) disable iff (!rstn_in)
        (wr_in && addr_in == BUS_CONTROL_OFS && !wdata_in[TXFLUSH_BIT] && st_ff.control[TXFLUSH_BIT] && !tx_done)
            |=> st_ff.control[TXFLUSH_BIT];
    endproperty
    a_tx_zero_write: assert property (p_tx_zero_write) else $error("Zero write ended transmit flush");

    property p_rx_zero_write;
        @(posedge clk_in) disable iff (!rstn_in)
        (wr_in && addr_in == BUS_CONTROL_OFS && !wdata_in[RXFLUSH_BIT] && st_ff.control[RXFLUSH_BIT] && !rx_done)
            |=> st_ff.control[RXFLUSH_BIT];
    endproperty
    a_rx_zero_write: assert property (p_rx_zero_write) else $error("Zero write ended receive flush");

    property p_gc_hw;
        @(posedge clk_in) disable iff (!rstn_in)
        (is_gc && gc_hw_in) |=> rx_fifo_push_out && !gc_action_out && rx_fifo_data_out == GENCALL_CODE;
    endproperty
    a_gc_hw: assert property (p_gc_hw) else $error("Hardware general call not transparent");

    c_tx_flush: cover property (@(posedge clk_in) disable iff (!rstn_in) tx_done);
    c_rx_flush: cover property (@(posedge clk_in) disable iff (!rstn_in) rx_done);
    c_gc_direct: cover property (@(posedge clk_in) disable iff (!rstn_in) gc_action_out);
    c_dma_end: cover property (@(posedge clk_in) disable iff (!rstn_in) $fell(st_ff.control[DMATX_BIT]));
    c_gc_hw: cover property (@(posedge clk_in) disable iff (!rstn_in) is_gc && gc_hw_in);
endmodule
`default_nettype wire

//--- sim/gcf_bus_partner.sv
// Far side model: link clock and received address bytes
`timescale 1ns/1ps
`default_nettype none
module gcf_bus_partner (
    input wire logic clk_in,
    input wire logic link_run_in,
    output logic link_clk_out,
    output logic gc_valid_out,
    output logic [7:0] gc_byte_out,
    output logic gc_hw_out
);
    // ----------------------------------------
    // Link clock, low while no frame runs
    // ----------------------------------------
    initial begin
        link_clk_out = 1'b0;
        gc_valid_out = 1'b0;
        gc_byte_out = 8'h00;
        gc_hw_out = 1'b0;
        #7;
        forever begin
            #80;
            link_clk_out = link_run_in ? ~link_clk_out : 1'b0;
        end
    end

    // ----------------------------------------
    // One address byte, valid for one cycle
    // ----------------------------------------
    task automatic send(input logic [7:0] b, input logic hw);
        @(posedge clk_in);
        gc_valid_out <= 1'b1;
        gc_byte_out <= b;
        gc_hw_out <= hw;
        @(posedge clk_in);
        gc_valid_out <= 1'b0;
        gc_byte_out <= ~b; // Released lines show no stale byte
        gc_hw_out <= ~hw;
    endtask
endmodule
`default_nettype wire

//--- sim/i2c_general_call_flush_ctrl_test.sv
// Self-checking testbench of the bus control block
`timescale 1ns/1ps
`default_nettype none
module i2c_general_call_flush_ctrl_test
    import gcf_pkg::*;
;
    // ----------------------------------------
    // Signals
    // ----------------------------------------
    logic clk_in = 1'b0;
    logic rstn_in = 1'b0;
    logic [7:0] addr_in = 8'h00;
    logic [31:0] wdata_in = 32'h0000_0000;
    logic wr_in = 1'b0;
    logic rd_in = 1'b0;
    logic tx_fifo_level_in = 1'b0;
    logic dma_eot_in = 1'b0;
    logic link_run = 1'b0;
    logic link_clk, gc_valid, gc_hw, push, act, req, txr, rxr, irq_out;
    logic [7:0] gc_byte, push_data, push_byte;
    logic [31:0] rdata_out, d, fl;
    int n_fail = 0;
    int n_compared = 0;
    int n_push, n_act, k;
    int n_prst [2];
    bit gc_ctl [4] = '{0, 1, 1, 0};
    bit gc_hwt [4] = '{0, 0, 1, 0};
    logic [7:0] gc_b [4] = '{8'h00, 8'h00, 8'h00, 8'h5a};
    logic [7:0] ofs [5] = '{BUS_CONTROL_OFS, BUS_STATUS_OFS, IRQ_STATUS_OFS, IRQ_MASK_OFS, 8'h10};
    logic is_gc, exp_push, exp_act;

    always #10 clk_in = ~clk_in;

    gcf_ctrl i_gcf_ctrl (.clk_in(clk_in), .rstn_in(rstn_in), .addr_in(addr_in), .wdata_in(wdata_in),
        .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out), .link_clk_in(link_clk),
        .gc_valid_in(gc_valid), .gc_byte_in(gc_byte), .gc_hw_in(gc_hw), .rx_fifo_push_out(push),
        .rx_fifo_data_out(push_data), .gc_action_out(act), .tx_fifo_level_in(tx_fifo_level_in),
        .dma_eot_in(dma_eot_in), .dma_tx_req_out(req), .tx_path_reset_out(txr),
        .rx_path_reset_out(rxr), .irq_out(irq_out));

    gcf_bus_partner i_gcf_bus_partner (.clk_in(clk_in), .link_run_in(link_run),
        .link_clk_out(link_clk), .gc_valid_out(gc_valid), .gc_byte_out(gc_byte), .gc_hw_out(gc_hw));

    // Pulse and path reset monitors
    always @(posedge clk_in) begin
        if (push === 1'b1) begin
            n_push++;
            push_byte = push_data;
        end
        if (act === 1'b1) n_act++;
        if (txr === 1'b1) n_prst[0]++;
        if (rxr === 1'b1) n_prst[1]++;
    end

    // ----------------------------------------
    // Register bus tasks
    // ----------------------------------------
    task automatic wr(input logic [7:0] a, input logic [31:0] v);
        @(posedge clk_in);
        addr_in <= a;
        wdata_in <= v;
        wr_in <= 1'b1;
        @(posedge clk_in);
        wr_in <= 1'b0;
        #1;
    endtask

    task automatic rd(input logic [7:0] a, output logic [31:0] v);
        @(posedge clk_in);
        addr_in <= a;
        rd_in <= 1'b1;
        @(posedge clk_in);
        rd_in <= 1'b0;
        #1 v = rdata_out;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            n_fail++;
            $display("ERROR at %0t: seen %h expected %h", $time, got, exp);
        end
    endtask

    task automatic end_sim();
        $display("compared %0d mismatches %0d", n_compared, n_fail);
        if (n_fail == 0 && n_compared > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    // Watchdog against a hang
    initial begin
        #200_000;
        n_fail++;
        $display("ERROR at %0t: watchdog expired", $time);
        end_sim();
    end

    // ----------------------------------------
    // Test sequence
    // ----------------------------------------
    initial begin
        repeat (12) @(posedge clk_in);
        rstn_in <= 1'b1;
        // Reset values, unmapped place ignored
        wr(8'h10, 32'hffff_ffff);
        for (int i = 0; i < 5; i++) begin
            rd(ofs[i], d);
            chk(d, 32'h0000_0000);
        end
        chk(irq_out, 1'b0);
        $display("test registers done");

        // Flushes: tx then rx, irq unmasked then masked
        for (int i = 0; i < 2; i++) begin
            wr(IRQ_MASK_OFS, (i == 0) ? 32'h0000_000f : 32'h0000_0000);
            rd(IRQ_MASK_OFS, d);
            chk(d, (i == 0) ? 32'h0000_000f : 32'h0000_0000);
            n_prst = '{0, 0};
            fl = 32'h0000_0001 << (TXFLUSH_BIT + i);
            wr(BUS_CONTROL_OFS, 32'h0000_8040 | fl);
            rd(BUS_CONTROL_OFS, d);
            chk(d, 32'h0000_8040 | fl);
            wr(BUS_CONTROL_OFS, 32'h0000_8040);
            rd(BUS_CONTROL_OFS, d);
            chk(d, 32'h0000_8040 | fl);
            link_run = 1'b1;
            // Poll the flush bit, FIFOs left alone meanwhile
            k = 0;
            do begin
                rd(BUS_CONTROL_OFS, d);
                k++;
            end while (d[TXFLUSH_BIT + i] !== 1'b0 && k < 200);
            link_run = 1'b0;
            chk(d, 32'h0000_8040);
            chk(n_prst[i] > 0, 1);
            chk(n_prst[1 - i], 0);
            chk(irq_out, i == 0);
            rd(IRQ_STATUS_OFS, d);
            chk(d, 32'h0000_0001 << i);
            chk(irq_out, 1'b0);
            rd(IRQ_STATUS_OFS, d);
            chk(d, 32'h0000_0000);
        end
        $display("test flush done");

        // General call handling table
        for (int j = 0; j < 4; j++) begin
            is_gc = (gc_b[j] == GENCALL_CODE);
            exp_push = is_gc && (!gc_ctl[j] || gc_hwt[j]);
            exp_act = is_gc && gc_ctl[j] && !gc_hwt[j];
            wr(BUS_CONTROL_OFS, 32'(gc_ctl[j]) << GENCALL_BIT);
            n_push = 0;
            n_act = 0;
            i_gcf_bus_partner.send(gc_b[j], gc_hwt[j]);
            repeat (3) @(posedge clk_in);
            chk(n_push, exp_push);
            if (exp_push) chk(push_byte, GENCALL_CODE);
            chk(n_act, exp_act);
            rd(BUS_STATUS_OFS, d);
            if (exp_act) chk(d[15:0], GC_STATUS_WORD);
            rd(IRQ_STATUS_OFS, d);
            chk(d, 32'(exp_act) << EV_GC_DIRECT);
        end
        $display("test general call done");

        // DMA transmit idle and end of transfer
        @(posedge clk_in);
        tx_fifo_level_in <= 1'b1;
        @(posedge clk_in);
        #1 chk(req, 1'b0);
        wr(BUS_CONTROL_OFS, 32'h0000_0200); // Receive DMA kept off
        chk(req, 1'b1);
        @(posedge clk_in);
        dma_eot_in <= 1'b1;
        @(posedge clk_in);
        dma_eot_in <= 1'b0;
        @(posedge clk_in);
        #1 chk(req, 1'b0);
        rd(BUS_CONTROL_OFS, d);
        chk(d, 32'h0000_0000);
        rd(IRQ_STATUS_OFS, d);
        chk(d, 32'h0000_0001 << EV_DMATX_END);
        $display("test dma done");
        end_sim();
    end
endmodule
`default_nettype wire
